// file: rtl/fspc_pkg.sv
package fspc_pkg;

  // ********************************
  // Register map
  // ********************************
  localparam logic [3:0]  A_CTRL = 4'h0;
  localparam logic [3:0]  A_KEY  = 4'h4;
  localparam logic [3:0]  A_PAGE = 4'h8;
  localparam logic [3:0]  A_STAT = 4'hC;

  localparam int          CTL_WR    = 15;
  localparam int          CTL_PERMIT = 14;
  localparam int          CTL_ERR   = 13;
  localparam int          CTL_ERASE = 6;
  localparam int          STAT_BUSY = 0;
  localparam int          STAT_KEY  = 1;

  localparam logic [7:0]  KEY_FIRST  = 8'h55;
  localparam logic [7:0]  KEY_SECOND = 8'hAA;

  // ********************************
  // Geometry
  // ********************************
  localparam int          BUF_WORDS  = 64;
  localparam logic [5:0]  IDX_LAST   = 6'h3F;
  localparam logic [23:0] ROW_MASK   = 24'hFFFF80;
  localparam logic [23:0] PAGE_MASK  = 24'hFFFC00;

  // ********************************
  // Operation codes
  // ********************************
  localparam logic [3:0]  OP_1111 = 4'hF;
  localparam logic [3:0]  OP_1101 = 4'hD;
  localparam logic [3:0]  OP_1100 = 4'hC;
  localparam logic [3:0]  OP_0011 = 4'h3;
  localparam logic [3:0]  OP_0010 = 4'h2;
  localparam logic [3:0]  OP_0001 = 4'h1;
  localparam logic [3:0]  OP_0000 = 4'h0;

  typedef enum logic [2:0] {
    K_NOP   = 3'b000,
    K_ROW   = 3'b001,
    K_WORD  = 3'b010,
    K_PAGE  = 3'b011,
    K_BLK   = 3'b100,
    K_CFGP  = 3'b101
  } fspc_kind_e;

  typedef enum logic [1:0] {
    S_IDLE   = 2'b00,
    S_TIME   = 2'b01,
    S_COMMIT = 2'b10
  } fspc_st_e;

  typedef enum logic [1:0] {
    KEY_NONE  = 2'b00,
    KEY_HALF  = 2'b01,
    KEY_ARMED = 2'b10
  } fspc_key_e;

  function automatic fspc_kind_e fspc_decode(input logic ers, input logic [3:0] op);
    fspc_kind_e k;
    k = K_NOP;
    if (ers) begin
      case (op)
        OP_1111, OP_1101, OP_1100, OP_0000: k = K_BLK;
        OP_0010: k = K_PAGE;
        default: k = K_NOP;
      endcase
    end else begin
      case (op)
        OP_0011: k = K_WORD;
        OP_0001: k = K_ROW;
        OP_0000: k = K_CFGP;
        default: k = K_NOP;
      endcase
    end
    return k;
  endfunction

endpackage

// file: rtl/fspc_top.sv
// The address map and the Wishbone slave port were chosen for this implementation.
`timescale 1ns/1ps
module fspc_top #(
  parameter int unsigned P_ROW_OSC   = 11064,
  parameter int unsigned P_WORD_OSC  = 2000,
  parameter int unsigned P_ERASE_OSC = 20000
) (
  input  wire logic        I_CLK,
  input  wire logic        I_SYS_RST,
  input  wire logic        I_POR_RST,
  input  wire logic        I_FAST_OSC,
  input  wire logic        I_WB_CYC,
  input  wire logic        I_WB_STB,
  input  wire logic        I_WB_WE,
  input  wire logic [3:0]  I_WB_ADR,
  input  wire logic [31:0] I_WB_DAT,
  input  wire logic [3:0]  I_WB_SEL,
  output logic [31:0]      O_WB_DAT,
  output logic             O_WB_ACK,
  input  wire logic        I_TBL_REQ,
  input  wire logic        I_TBL_WE,
  input  wire logic        I_TBL_HI,
  input  wire logic        I_TBL_BYTE,
  input  wire logic        I_TBL_BSEL,
  input  wire logic [15:0] I_TBL_EFF_ADDR,
  input  wire logic [15:0] I_TBL_WDATA,
  output logic             O_TBL_DONE,
  output logic [15:0]      O_TBL_RDATA,
  output logic             O_CORE_STALL,
  output logic [23:0]      O_FL_RADDR,
  input  wire logic [23:0] I_FL_RDATA,
  output logic             O_FL_WE,
  output logic             O_FL_ERS,
  output logic [4:0]       O_FL_OP,
  output logic [23:0]      O_FL_ADDR,
  output logic [23:0]      O_FL_WDATA
);
  import fspc_pkg::*;

  // ********************************
  // Declarations
  // ********************************
  logic             rst_any;
  logic             ack_r;
  logic [31:0]      rdat_r;
  logic             rd_ctl_r;
  logic             wb_go;
  logic             wr_go;
  logic             ctl_wr;
  logic             key_wr;
  logic             page_wr;
  logic [15:0]      ctl_rd;
  logic [15:0]      ctl_nxt;
  logic             start_req;
  logic             good_start;
  logic             bad_start;
  logic             wr_r;
  logic             permit_r;
  logic             err_r;
  logic             erase_r;
  logic [3:0]       op_r;
  logic [7:0]       page_r;
  fspc_key_e        key_st_r;
  fspc_st_e         st_r;
  fspc_kind_e       kind_r;
  fspc_kind_e       dec;
  logic [15:0]      cnt_r;
  logic [15:0]      lim_r;
  logic [5:0]       idx_r;
  logic [23:0]      base_r;
  logic             commit_last;
  logic             op_fin;
  logic             osc_s1;
  logic             osc_s2;
  logic             osc_s3;
  logic             osc_edge;
  logic [23:0]      buf_r [BUF_WORDS];
  logic             tbl_go;
  logic             pend_r;
  logic             done_r;
  logic             t_rd_r;
  logic             t_hi_r;
  logic             t_byte_r;
  logic             t_bsel_r;
  logic [23:0]      raddr_r;
  logic [23:0]      op_addr_r;
  logic [15:0]      rdata_r;
  logic [5:0]       bi;
  logic             fl_we_r;
  logic             fl_ers_r;
  logic [4:0]       fl_op_r;
  logic [23:0]      fl_addr_r;
  logic [23:0]      fl_wdata_r;

  default clocking cb @(posedge I_CLK);
  endclocking
  default disable iff (I_POR_RST || I_SYS_RST);

  // ********************************
  // Functions
  // ********************************
  function automatic logic [15:0] merge16(input logic [15:0] o,
                                          input logic [15:0] n,
                                          input logic [1:0]  s);
    logic [15:0] r;
    r = o;
    if (s[0]) r[7:0] = n[7:0];
    if (s[1]) r[15:8] = n[15:8];
    return r;
  endfunction

  function automatic logic [15:0] op_lim(input fspc_kind_e k);
    logic [15:0] l;
    case (k)
      K_ROW:          l = 16'(P_ROW_OSC);
      K_WORD, K_CFGP: l = 16'(P_WORD_OSC);
      K_PAGE, K_BLK:  l = 16'(P_ERASE_OSC);
      default:        l = 16'h0000;
    endcase
    return l;
  endfunction

  function automatic logic [23:0] align(input fspc_kind_e k, input logic [23:0] a);
    logic [23:0] r;
    case (k)
      K_ROW:   r = a & ROW_MASK;
      K_PAGE:  r = a & PAGE_MASK;
      default: r = a;
    endcase
    return r;
  endfunction

  // ********************************
  // Bus slave
  // ********************************
  assign rst_any    = I_POR_RST | I_SYS_RST;
  assign wb_go      = I_WB_CYC & I_WB_STB & ~ack_r;
  assign wr_go      = wb_go & I_WB_WE;
  assign ctl_wr     = wr_go && (I_WB_ADR == A_CTRL);
  assign key_wr     = wr_go && (I_WB_ADR == A_KEY);
  assign page_wr    = wr_go && (I_WB_ADR == A_PAGE);
  assign O_WB_ACK   = ack_r;
  assign O_WB_DAT   = rdat_r;

  always_comb begin
    ctl_rd            = 16'h0000;
    ctl_rd[CTL_WR]    = wr_r;
    ctl_rd[CTL_PERMIT] = permit_r;
    ctl_rd[CTL_ERR]   = err_r;
    ctl_rd[CTL_ERASE] = erase_r;
    ctl_rd[3:0]       = op_r;
  end

  assign ctl_nxt = merge16(ctl_rd, I_WB_DAT[15:0], I_WB_SEL[1:0]);

  always_ff @(posedge I_CLK) begin
    if (rst_any) begin
      ack_r    <= 1'b0;
      rdat_r   <= 32'h0000_0000;
      rd_ctl_r <= 1'b0;
    end else begin
      ack_r    <= wb_go;
      rd_ctl_r <= wb_go && !I_WB_WE && (I_WB_ADR == A_CTRL);
      if (wb_go && !I_WB_WE) begin
        rdat_r <= 32'h0000_0000;
        case (I_WB_ADR)
          A_CTRL:  rdat_r[15:0] <= ctl_rd;
          A_PAGE:  rdat_r[7:0] <= page_r;
          A_STAT: begin
            rdat_r[STAT_BUSY]          <= wr_r;
            rdat_r[STAT_KEY+1:STAT_KEY] <= key_st_r;
          end
          default: rdat_r <= 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge I_CLK) begin
    if (rst_any) begin
      page_r <= 8'h00;
    end else if (page_wr && I_WB_SEL[0]) begin
      page_r <= I_WB_DAT[7:0];
    end
  end

  // ********************************
  // Unlock sequence
  // ********************************
  always_ff @(posedge I_CLK) begin
    if (rst_any) begin
      key_st_r <= KEY_NONE;
    end else if (wr_go) begin
      if (key_wr && I_WB_SEL[0] && I_WB_DAT[7:0] == KEY_FIRST) begin
        key_st_r <= KEY_HALF;
      end else if (key_wr && I_WB_SEL[0] && I_WB_DAT[7:0] == KEY_SECOND
                   && key_st_r == KEY_HALF) begin
        key_st_r <= KEY_ARMED;
      end else begin
        key_st_r <= KEY_NONE;
      end
    end
  end

  a_key_void: assert property (wr_go && !key_wr |=> key_st_r == KEY_NONE)
    else $error("unlock state survived another write");

  // ********************************
  // Control register
  // ********************************
  assign start_req  = ctl_wr && ctl_nxt[CTL_WR] && !wr_r && (st_r == S_IDLE);
  assign good_start = start_req && (key_st_r == KEY_ARMED) && ctl_nxt[CTL_PERMIT];
  assign bad_start  = start_req && !good_start;
  assign dec        = fspc_decode(ctl_nxt[CTL_ERASE], ctl_nxt[3:0]);

  // Power-on reset only; a system reset mid-operation terminates it
  always_ff @(posedge I_CLK) begin
    if (I_POR_RST) begin
      wr_r    <= 1'b0;
      permit_r <= 1'b0;
      erase_r <= 1'b0;
      op_r    <= 4'h0;
    end else begin
      if (ctl_wr && !wr_r) begin
        permit_r <= ctl_nxt[CTL_PERMIT];
        erase_r <= ctl_nxt[CTL_ERASE];
        op_r    <= ctl_nxt[3:0];
      end
      if (I_SYS_RST || op_fin) begin
        wr_r <= 1'b0;
      end else if (good_start) begin
        wr_r <= 1'b1;
      end
    end
  end

  // Hardware set wins over software clear
  always_ff @(posedge I_CLK) begin
    if (I_POR_RST) begin
      err_r <= 1'b0;
    end else if (bad_start || (I_SYS_RST && wr_r)) begin
      err_r <= 1'b1;
    end else if (op_fin) begin
      err_r <= 1'b0;
    end else if (ctl_wr && !wr_r) begin
      err_r <= ctl_nxt[CTL_ERR];
    end
  end

  assign O_CORE_STALL = wr_r;

  a_bad_key: assert property (start_req && key_st_r != KEY_ARMED
                              |=> err_r && !wr_r && st_r == S_IDLE)
    else $error("start without unlock was accepted");
  a_permit_gate: assert property (start_req && !ctl_nxt[CTL_PERMIT]
                                |=> !wr_r && err_r)
    else $error("start with writes disabled was accepted");
  a_wr_stays: assert property (wr_r && !op_fin |=> wr_r)
    else $error("start bit dropped before completion");
  a_wr_clear: assert property (op_fin |=> !wr_r && !err_r && st_r == S_IDLE)
    else $error("start bit or error not cleared at completion");
  a_rsv_zero: assert property (ack_r && rd_ctl_r
                               |-> O_WB_DAT[12:7] == 6'h00 && O_WB_DAT[5:4] == 2'h0)
    else $error("unimplemented control bits read nonzero");

  // ********************************
  // Oscillator sampling
  // ********************************
  always_ff @(posedge I_CLK) begin
    if (rst_any) begin
      osc_s1 <= 1'b0;
      osc_s2 <= 1'b0;
      osc_s3 <= 1'b0;
    end else begin
      osc_s1 <= I_FAST_OSC;
      osc_s2 <= osc_s1;
      osc_s3 <= osc_s2;
    end
  end

  assign osc_edge = osc_s2 & ~osc_s3;

  // ********************************
  // Operation sequencer
  // ********************************
  assign commit_last = (kind_r != K_ROW) || (idx_r == IDX_LAST);
  assign op_fin      = (st_r == S_COMMIT) && commit_last;

  always_ff @(posedge I_CLK) begin
    if (rst_any) begin
      st_r   <= S_IDLE;
      kind_r <= K_NOP;
      cnt_r  <= 16'h0000;
      lim_r  <= 16'h0000;
      idx_r  <= 6'h00;
      base_r <= 24'h000000;
    end else begin
      case (st_r)
        S_IDLE: begin
          if (good_start) begin
            kind_r <= dec;
            lim_r  <= op_lim(dec);
            cnt_r  <= 16'h0000;
            base_r <= align(dec, op_addr_r);
            st_r   <= S_TIME;
          end
        end
        S_TIME: begin
          if (cnt_r >= lim_r) begin
            idx_r <= 6'h00;
            st_r  <= S_COMMIT;
          end else if (osc_edge) begin
            cnt_r <= cnt_r + 16'h0001;
          end
        end
        S_COMMIT: begin
          if (commit_last) begin
            st_r <= S_IDLE;
          end else begin
            idx_r <= idx_r + 6'h01;
          end
        end
        default: st_r <= S_IDLE;
      endcase
    end
  end

  a_osc_bound: assert property (st_r == S_TIME |-> cnt_r <= lim_r)
    else $error("oscillator count passed its limit");
  a_row_time: assert property (good_start && dec == K_ROW
                               |=> lim_r == 16'(P_ROW_OSC) && st_r == S_TIME)
    else $error("row timing not loaded");
  a_stall_hold: assert property (st_r != S_IDLE |-> O_CORE_STALL)
    else $error("core not stalled during operation");

  // ********************************
  // Flash array strobes
  // ********************************
  always_ff @(posedge I_CLK) begin
    if (rst_any) begin
      fl_we_r    <= 1'b0;
      fl_ers_r   <= 1'b0;
      fl_op_r    <= 5'h00;
      fl_addr_r  <= 24'h000000;
      fl_wdata_r <= 24'h000000;
    end else begin
      fl_we_r  <= 1'b0;
      fl_ers_r <= 1'b0;
      if (good_start) begin
        fl_op_r <= {ctl_nxt[CTL_ERASE], ctl_nxt[3:0]};
      end
      if (st_r == S_COMMIT) begin
        case (kind_r)
          K_ROW: begin
            fl_we_r    <= 1'b1;
            fl_addr_r  <= {base_r[23:7], idx_r, 1'b0};
            fl_wdata_r <= buf_r[idx_r];
          end
          K_WORD, K_CFGP: begin
            fl_we_r    <= 1'b1;
            fl_addr_r  <= base_r;
            fl_wdata_r <= buf_r[base_r[6:1]];
          end
          K_PAGE, K_BLK: begin
            fl_ers_r  <= 1'b1;
            fl_addr_r <= base_r;
          end
          default: fl_we_r <= 1'b0;
        endcase
      end
    end
  end

  assign O_FL_WE    = fl_we_r;
  assign O_FL_ERS   = fl_ers_r;
  assign O_FL_OP    = fl_op_r;
  assign O_FL_ADDR  = fl_addr_r;
  assign O_FL_WDATA = fl_wdata_r;

  a_row_burst: assert property (st_r == S_TIME && cnt_r >= lim_r && kind_r == K_ROW
                                |=> ##1 O_FL_WE [*8])
    else $error("row program burst broken");
  a_page_align: assert property (O_FL_ERS && kind_r == K_PAGE
                                 |-> O_FL_ADDR[9:0] == 10'h000)
    else $error("page erase address not aligned");

  // ********************************
  // Table access port
  // ********************************
  assign tbl_go = I_TBL_REQ && !wr_r && (st_r == S_IDLE);
  assign bi     = I_TBL_EFF_ADDR[6:1];

  // Holding buffer only; array untouched until a program cycle
  always_ff @(posedge I_CLK) begin
    if (tbl_go && I_TBL_WE) begin
      if (!I_TBL_HI) begin
        if (!I_TBL_BYTE) begin
          buf_r[bi][15:0] <= I_TBL_WDATA;
        end else if (I_TBL_BSEL) begin
          buf_r[bi][15:8] <= I_TBL_WDATA[7:0];
        end else begin
          buf_r[bi][7:0] <= I_TBL_WDATA[7:0];
        end
      end else if (!(I_TBL_BYTE && I_TBL_BSEL)) begin
        buf_r[bi][23:16] <= I_TBL_WDATA[7:0];
      end
    end
  end

  always_ff @(posedge I_CLK) begin
    if (rst_any) begin
      pend_r    <= 1'b0;
      done_r    <= 1'b0;
      t_rd_r    <= 1'b0;
      t_hi_r    <= 1'b0;
      t_byte_r  <= 1'b0;
      t_bsel_r  <= 1'b0;
      raddr_r   <= 24'h000000;
      op_addr_r <= 24'h000000;
      rdata_r   <= 16'h0000;
    end else begin
      pend_r <= tbl_go;
      done_r <= pend_r;
      if (tbl_go) begin
        t_rd_r   <= !I_TBL_WE;
        t_hi_r   <= I_TBL_HI;
        t_byte_r <= I_TBL_BYTE;
        t_bsel_r <= I_TBL_BSEL;
        if (I_TBL_WE) begin
          op_addr_r <= {page_r, I_TBL_EFF_ADDR};
        end else begin
          raddr_r <= {page_r, I_TBL_EFF_ADDR};
        end
      end
      if (pend_r && t_rd_r) begin
        if (!t_hi_r) begin
          if (!t_byte_r) begin
            rdata_r <= I_FL_RDATA[15:0];
          end else begin
            rdata_r <= {8'h00, t_bsel_r ? I_FL_RDATA[15:8] : I_FL_RDATA[7:0]};
          end
        end else if (t_byte_r && t_bsel_r) begin
          rdata_r <= 16'h0000;
        end else begin
          rdata_r <= {8'h00, I_FL_RDATA[23:16]};
        end
      end
    end
  end

  assign O_TBL_DONE  = done_r;
  assign O_TBL_RDATA = rdata_r;
  assign O_FL_RADDR  = raddr_r;

  a_tbl_two: assert property (tbl_go |=> !O_TBL_DONE ##1 O_TBL_DONE)
    else $error("table access not finished in two cycles");
  a_addr_form: assert property (tbl_go && !I_TBL_WE
                                |=> O_FL_RADDR == {$past(page_r), $past(I_TBL_EFF_ADDR)})
    else $error("table address not formed from page and offset");
  a_low_read: assert property (pend_r && t_rd_r && !t_hi_r && !t_byte_r
                               |=> O_TBL_RDATA == $past(I_FL_RDATA[15:0]))
    else $error("low word read wrong");
  a_high_read: assert property (pend_r && t_rd_r && t_hi_r && !t_byte_r
                                |=> O_TBL_RDATA == {8'h00, $past(I_FL_RDATA[23:16])})
    else $error("high byte read wrong");

endmodule

// file: verification/fspc_flash_model.sv
`timescale 1ns/1ps
// ****************************************
// Flash array model
// ****************************************
module fspc_flash_model (
  input  wire logic        i_clk,
  input  wire logic [23:0] i_raddr,
  output logic      [23:0] o_rdata,
  input  wire logic        i_we,
  input  wire logic        i_ers,
  input  wire logic [23:0] i_addr,
  input  wire logic [23:0] i_wdata
);
  logic [23:0] mem [logic [23:0]];
  int          we_cnt   = 0;
  int          ers_cnt  = 0;
  logic [23:0] ers_addr = 24'h000000;

  // Every cell reads an address-derived pattern, so a wrong address shows
  assign o_rdata = i_raddr ^ 24'h5A3C96;

  always @(posedge i_clk) begin
    if (i_we === 1'b1) begin
      mem[i_addr] = i_wdata;
      we_cnt++;
    end
    if (i_ers === 1'b1) begin
      ers_addr = i_addr;
      ers_cnt++;
    end
  end
endmodule

// file: verification/tb.sv
`timescale 1ns/1ps
module tb;
  import fspc_pkg::*;
  logic        clk = 1'b0, osc = 1'b0, sys_rst = 1'b1, por_rst = 1'b1;
  logic [4:0]  fl_op;
  logic        cyc = 1'b0, stb = 1'b0, we = 1'b0, treq = 1'b0, twe = 1'b0, thi = 1'b0;
  logic        tbyte = 1'b0, tbsel = 1'b0;
  logic [3:0]  adr = 4'h0, sel = 4'h0;
  logic [31:0] wdat = 32'h00000000, q, rdat;
  logic [15:0] tea = 16'h0000, twd = 16'h0000, trd;
  logic        ack, tdone, stall, fl_we, fl_ers;
  logic [23:0] fl_raddr, fl_rdata, fl_addr, fl_wdata, p;
  int          err_count = 0, tests_run = 0, stall_cyc = 0, w0;
  logic [15:0] ops [14] = '{16'h4001, 16'h4003, 16'h4000, 16'h400F, 16'h400D, 16'h400C, 16'h4002,
                            16'h404F, 16'h404D, 16'h404C, 16'h4040, 16'h4042, 16'h4043, 16'h4041};
  int          wexp [14] = '{64, 1, 1, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0};
  int          eexp [14] = '{0, 0, 0, 0, 0, 0, 0, 1, 1, 1, 1, 1, 0, 0};

  fspc_top #(.P_ROW_OSC(8), .P_WORD_OSC(4), .P_ERASE_OSC(4)) fspc_top_inst (
    .I_CLK(clk), .I_SYS_RST(sys_rst), .I_POR_RST(por_rst), .I_FAST_OSC(osc),
    .I_WB_CYC(cyc), .I_WB_STB(stb), .I_WB_WE(we), .I_WB_ADR(adr), .I_WB_DAT(wdat), .I_WB_SEL(sel),
    .O_WB_DAT(rdat), .O_WB_ACK(ack), .I_TBL_REQ(treq), .I_TBL_WE(twe), .I_TBL_HI(thi),
    .I_TBL_BYTE(tbyte), .I_TBL_BSEL(tbsel), .I_TBL_EFF_ADDR(tea), .I_TBL_WDATA(twd), .O_TBL_DONE(tdone),
    .O_TBL_RDATA(trd), .O_CORE_STALL(stall), .O_FL_RADDR(fl_raddr), .I_FL_RDATA(fl_rdata),
    .O_FL_WE(fl_we), .O_FL_ERS(fl_ers), .O_FL_OP(fl_op), .O_FL_ADDR(fl_addr), .O_FL_WDATA(fl_wdata));

  fspc_flash_model fspc_flash_model_inst (
    .i_clk(clk), .i_raddr(fl_raddr), .o_rdata(fl_rdata), .i_we(fl_we), .i_ers(fl_ers),
    .i_addr(fl_addr), .i_wdata(fl_wdata));

  initial forever #2 clk = ~clk;
  initial forever #67.843 osc = ~osc;
  always @(posedge clk) if (stall === 1'b1) stall_cyc++;

  // ****************************************
  // Checking and closing
  // ****************************************
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      $display("Error %s expected %h seen %h", nm, e, g);
      err_count++;
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d errors %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic hang(input string nm);
    $display("Error %s expected answer seen none", nm);
    err_count++;
    tally_and_finish();
  endtask

  // ****************************************
  // Bus and table access
  // ****************************************
  task automatic wb(input logic w, input logic [3:0] a, input logic [15:0] d);
    int n;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= {16'h0000, d};
    sel <= 4'h3;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 40);
    if (ack !== 1'b1) hang("bus ack");
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask

  task automatic tbl(input logic w, input logic h, input logic [15:0] ea, input logic [15:0] d);
    int n;
    @(posedge clk);
    treq <= 1'b1;
    twe <= w;
    thi <= h;
    tea <= ea;
    twd <= d;
    n = 0;
    do begin
      @(posedge clk);
      treq <= 1'b0;
      n++;
    end while (tdone !== 1'b1 && n < 20);
    if (tdone !== 1'b1) hang("table done");
    chk("table latency", 32'd3, 32'(n));
    q = {16'h0000, trd};
  endtask

  // Unlock, start, then either run to completion or abort by system reset
  task automatic do_op(input logic [15:0] ctl, input int we_e, input int ers_e, input logic abort);
    int n, e0;
    w0 = fspc_flash_model_inst.we_cnt;
    e0 = fspc_flash_model_inst.ers_cnt;
    wb(1'b1, A_CTRL, ctl);
    wb(1'b1, A_KEY, {8'h00, KEY_FIRST});
    wb(1'b1, A_KEY, {8'h00, KEY_SECOND});
    stall_cyc = 0;
    wb(1'b1, A_CTRL, ctl | 16'h8000);
    repeat (2) @(posedge clk);
    if (abort) begin
      wb(1'b1, A_CTRL, 16'h0000);
      chk("stall held", 32'h1, {31'h0, stall});
      sys_rst <= 1'b1;
      @(posedge clk);
      sys_rst <= 1'b0;
      wb(1'b0, A_CTRL, 16'h0000);
      chk("control after abort", {16'h0000, ctl | 16'h2000}, q);
    end else begin
      n = 0;
      while (stall !== 1'b0 && n < 3000) begin
        @(posedge clk);
        n++;
      end
      if (stall !== 1'b0) hang("stall release");
      wb(1'b0, A_CTRL, 16'h0000);
      chk("control done", {16'h0000, ctl}, q);
      chk("launched op", {27'h0, ctl[6], ctl[3:0]}, {27'h0, fl_op});
      chk("write pulses", 32'(we_e), 32'(fspc_flash_model_inst.we_cnt - w0));
      chk("erase pulses", 32'(ers_e), 32'(fspc_flash_model_inst.ers_cnt - e0));
      if (ctl == 16'h4001) chk("row time", 32'h1, {31'h0, stall_cyc > 230 && stall_cyc < 400});
    end
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    repeat (5) @(posedge clk);
    sys_rst <= 1'b0;
    por_rst <= 1'b0;
    wb(1'b0, A_CTRL, 16'h0000);
    chk("control reset", 32'h0, q);
    wb(1'b1, A_CTRL, 16'hFFFF);
    wb(1'b0, A_CTRL, 16'h0000);
    chk("control no key", 32'h604F, q);
    wb(1'b0, A_KEY, 16'h0000);
    chk("key read", 32'h0, q);
    wb(1'b0, 4'h2, 16'h0000);
    chk("unmapped read", 32'h0, q);
    wb(1'b1, A_PAGE, 16'h0001);
    p = 24'h010246 ^ 24'h5A3C96;
    tbl(1'b0, 1'b0, 16'h0246, 16'h0000);
    chk("read low", {16'h0000, p[15:0]}, q);
    tbl(1'b0, 1'b1, 16'h0246, 16'h0000);
    chk("read high", {24'h000000, p[23:16]}, q);
    tbyte <= 1'b1;
    tbsel <= 1'b1;
    tbl(1'b0, 1'b0, 16'h0246, 16'h0000);
    chk("read low byte", {24'h000000, p[15:8]}, q);
    tbl(1'b0, 1'b1, 16'h0246, 16'h0000);
    chk("read phantom byte", 32'h0, q);
    tbyte <= 1'b0;
    tbsel <= 1'b0;
    for (int i = 0; i < 64; i++) begin
      tbl(1'b1, 1'b0, 16'(2 * i), 16'h1000 + 16'(i));
      tbl(1'b1, 1'b1, 16'(2 * i), 16'h0080 + 16'(i));
    end
    for (int i = 0; i < 14; i++) begin
      do_op(ops[i], wexp[i], eexp[i], 1'b0);
      if (ops[i] == 16'h4042) chk("page base", 32'h010000, {8'h00, fspc_flash_model_inst.ers_addr});
    end
    for (int i = 0; i < 64; i++) begin
      chk("row data", {8'h00, 8'h80 + 8'(i), 16'h1000 + 16'(i)},
          {8'h00, fspc_flash_model_inst.mem[24'h010000 + 24'(2 * i)]});
    end
    w0 = fspc_flash_model_inst.we_cnt;
    wb(1'b1, A_CTRL, 16'h4001);
    wb(1'b1, A_KEY, 16'h0055);
    wb(1'b1, A_PAGE, 16'h0001);
    wb(1'b1, A_KEY, 16'h00AA);
    wb(1'b1, A_CTRL, 16'hC001);
    wb(1'b0, A_CTRL, 16'h0000);
    chk("voided key", 32'h6001, q);
    wb(1'b1, A_CTRL, 16'h0001);
    wb(1'b1, A_KEY, 16'h0055);
    wb(1'b1, A_KEY, 16'h00AA);
    wb(1'b1, A_CTRL, 16'h8001);
    wb(1'b0, A_CTRL, 16'h0000);
    chk("permit off", 32'h2001, q);
    chk("no stray writes", 32'(w0), 32'(fspc_flash_model_inst.we_cnt));
    do_op(16'h4001, 0, 0, 1'b1);
    por_rst <= 1'b1;
    @(posedge clk);
    por_rst <= 1'b0;
    wb(1'b0, A_CTRL, 16'h0000);
    chk("control power on", 32'h0, q);
    tally_and_finish();
  end
endmodule
